// file: include/mlsg_pkg.sv
// Package for the motor load-shed and stall guard: widths, timing and config carriers.
// Assumes one 100 MHz clock; current samples arrive already on that clock.
package mlsg_pkg;

   // ==========================================================
   // Widths
   localparam int CUR_W = 16;   // Motor current sample, unsigned
   localparam int DLY_W = 16;   // Delay settings, in ticks
   localparam int TICK_W = 20;  // Tick prescaler counter
   localparam int PROD_W = 24;  // Scaled current for the hysteresis compare
   localparam int N_STALL = 2;  // Independent stall-load elements

   // ==========================================================
   // Timing: delays are counted in 1 ms ticks
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000000;
   localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;

   // ==========================================================
   // Dropout hysteresis: element stays picked while cur*100 > pickup*98
   localparam logic [PROD_W-1:0] HYST_DEN = 24'h000064;  // 100
   localparam logic [PROD_W-1:0] HYST_NUM = 24'h000062;  // 98

   // ==========================================================
   // Reset values
   localparam logic [DLY_W-1:0] DLY_ZERO = 16'h0000;
   localparam logic [TICK_W-1:0] TICK_ZERO = 20'h00000;
   localparam logic [DLY_W-1:0] DLY_ONE = 16'h0001;
   localparam logic [TICK_W-1:0] TICK_ONE = 20'h00001;

   // ==========================================================
   // Load-relief settings
   typedef struct packed {
      logic enable;               // Function switched on
      logic open_contact;         // 1: contact opens to shed, 0: closes
      logic [CUR_W-1:0] pickup;   // Shed above this current
      logic [CUR_W-1:0] rel_lvl;  // Release below this current
      logic [DLY_W-1:0] pu_dly;   // Pickup delay, ticks
      logic [DLY_W-1:0] rl_dly;   // Release delay, ticks
   } mlsg_relief_cfg_t;

   // Stall-load element settings
   typedef struct packed {
      logic trip_en;              // Mode active: trip allowed
      logic trip_block;           // Trip command blocked: alarm only
      logic [CUR_W-1:0] pickup;   // Alarm above this current
      logic [DLY_W-1:0] trip_dly; // Trip delay after alarm, ticks
   } mlsg_stall_cfg_t;

   // Stall-load element indications
   typedef struct packed {
      logic alarm;
      logic trip;
   } mlsg_stall_out_t;

endpackage : mlsg_pkg

// file: rtl/mlsg_stall_elem.sv
// One stall-load element: hysteresis pickup, run delay, trip delay.
// Assumes tick is a one-cycle pulse on ref_clk and armed is already registered.
module mlsg_stall_elem
(
   // Clock and control
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   input wire logic tick,
   input wire logic armed,
   // Measurement and settings
   input wire logic [mlsg_pkg::CUR_W-1:0] cur,
   input wire logic [mlsg_pkg::DLY_W-1:0] run_dly,
   input wire mlsg_pkg::mlsg_stall_cfg_t cfg,
   // Indications
   output mlsg_pkg::mlsg_stall_out_t ind
);

   // ==========================================================
   // Comparators
   logic above_pk;
   logic held;
   logic [mlsg_pkg::PROD_W-1:0] cur_x;
   logic [mlsg_pkg::PROD_W-1:0] pk_x;
   logic picked_q;
   logic picked_d;
   logic [mlsg_pkg::DLY_W-1:0] run_cnt_q;
   logic [mlsg_pkg::DLY_W-1:0] trip_cnt_q;
   logic alarm_q;
   logic trip_q;

   // Scaled compare avoids a divider for the 98 percent dropout level
   assign cur_x = mlsg_pkg::PROD_W'(cur) * mlsg_pkg::HYST_DEN;
   assign pk_x = mlsg_pkg::PROD_W'(cfg.pickup) * mlsg_pkg::HYST_NUM;
   assign above_pk = cur > cfg.pickup;
   assign held = cur_x > pk_x;

   // Pickup with hysteresis; disarmed elements stay dropped out
   always_comb
   begin
      if (!armed)
         picked_d = 1'b0;
      else if (picked_q)
         picked_d = held;
      else
         picked_d = above_pk;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         picked_q <= 1'b0;
      else if (clk_en)
         picked_q <= picked_d;
   end

   // ==========================================================
   // Run delay filters short transients; ordered compares let a lowered setting act at once
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         run_cnt_q <= mlsg_pkg::DLY_ZERO;
      else if (clk_en)
      begin
         if (!picked_q)
            run_cnt_q <= mlsg_pkg::DLY_ZERO;
         else if (tick && run_cnt_q < run_dly)
            run_cnt_q <= run_cnt_q + mlsg_pkg::DLY_ONE;
      end
   end

   // Alarm drops with the pickup, no latching here
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         alarm_q <= 1'b0;
      else if (clk_en)
         alarm_q <= picked_d && picked_q && run_cnt_q >= run_dly;
   end

   // ==========================================================
   // Trip delay runs only while alarmed, restarts on dropout
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         trip_cnt_q <= mlsg_pkg::DLY_ZERO;
      else if (clk_en)
      begin
         if (!alarm_q)
            trip_cnt_q <= mlsg_pkg::DLY_ZERO;
         else if (tick && trip_cnt_q < cfg.trip_dly)
            trip_cnt_q <= trip_cnt_q + mlsg_pkg::DLY_ONE;
      end
   end

   // Blocked trip leaves the element as a pure alarm
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         trip_q <= 1'b0;
      else if (clk_en)
         trip_q <= alarm_q && picked_d && trip_cnt_q >= cfg.trip_dly
                   && cfg.trip_en && !cfg.trip_block;
   end

   assign ind.alarm = alarm_q;
   assign ind.trip = trip_q;

   // ==========================================================
   // Checks
   sequence s_disarmed;
      clk_en && !armed;
   endsequence

   property p_start_suppress;
      @(posedge ref_clk) disable iff (!rst_b)
      s_disarmed |=> !alarm_q && !trip_q;
   endproperty
   a_start_suppress: assert property (p_start_suppress) else $error("Stall output while disarmed");

   property p_trip_needs_mode;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(trip_q) |-> $past(cfg.trip_en) && !$past(cfg.trip_block) && $past(alarm_q);
   endproperty
   a_trip_needs_mode: assert property (p_trip_needs_mode) else $error("Trip without mode or alarm");

   property p_block_alarm_only;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && cfg.trip_block |=> !trip_q;
   endproperty
   a_block_alarm_only: assert property (p_block_alarm_only) else $error("Trip while blocked");

   property p_hyst_hold;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && armed && picked_q && held |=> picked_q;
   endproperty
   a_hyst_hold: assert property (p_hyst_hold) else $error("Dropout above 98 percent");

   property p_drop_clears;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && !picked_d |=> !alarm_q && !trip_q ##1 !trip_q;
   endproperty
   a_drop_clears: assert property (p_drop_clears) else $error("Indication held after dropout");

   // Run counter clears one edge after the dropout registers
   property p_run_restart;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && !picked_q |=> run_cnt_q == mlsg_pkg::DLY_ZERO;
   endproperty
   a_run_restart: assert property (p_run_restart) else $error("Run delay not restarted");

endmodule : mlsg_stall_elem

// file: rtl/mlsg_top.sv
// Motor load-relief contact and two stall-load supervision elements.
// Assumes current samples, motor running state and settings are on ref_clk already.
// Notes on behaviour
// - When enabled, drive the load-relief contact, closing or opening as configured.
// - Shed only after current stays above pickup longer than the pickup delay.
// - After current falls below release, wait the release delay before releasing.
// - Load relief works only while the motor is running, idle otherwise.
// - Two independent stall elements, each with own pickup, delay and mode.
// - Stall alarm rises once current exceeds that element's pickup.
// - Stall trip only with mode active and trip delay fully elapsed above pickup.
// - A blocked trip leaves the element working as a plain alarm.
// - Start delay suppresses stall alarm and trip after a motor start.
// - Run delay keeps short running transients from raising alarms or trips.
// - A picked element drops out at or below 98 percent of pickup, or when the motor stops.
module mlsg_top
#(
   parameter int TICK_CYCLES = mlsg_pkg::TICK_CYC
)
(
   // Clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   input wire logic clk_en,
   // Measurement and motor state
   input wire logic [mlsg_pkg::CUR_W-1:0] cur,
   input wire logic motor_running,
   // Load-relief settings
   input wire mlsg_pkg::mlsg_relief_cfg_t load_relief_function,
   // Stall-load settings
   input wire logic [mlsg_pkg::DLY_W-1:0] start_dly,
   input wire logic [mlsg_pkg::DLY_W-1:0] run_dly,
   input wire mlsg_pkg::mlsg_stall_cfg_t stall_cfg [mlsg_pkg::N_STALL],
   // Outputs
   output logic relief_contact_q,
   output mlsg_pkg::mlsg_stall_out_t stall_ind [mlsg_pkg::N_STALL]
);

   // ==========================================================
   // Tick prescaler
   logic [mlsg_pkg::TICK_W-1:0] tick_cnt_q;
   logic tick_q;

   // Delays count in ticks so 16-bit settings cover over a minute
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         tick_cnt_q <= mlsg_pkg::TICK_ZERO;
         tick_q <= 1'b0;
      end
      else if (clk_en)
      begin
         tick_q <= tick_cnt_q == mlsg_pkg::TICK_W'(TICK_CYCLES - 1);
         if (tick_cnt_q == mlsg_pkg::TICK_W'(TICK_CYCLES - 1))
            tick_cnt_q <= mlsg_pkg::TICK_ZERO;
         else
            tick_cnt_q <= tick_cnt_q + mlsg_pkg::TICK_ONE;
      end
   end

   // ==========================================================
   // Start delay arms the stall elements after a start
   logic run_seen_q;
   logic armed_q;
   logic [mlsg_pkg::DLY_W-1:0] st_cnt_q;

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
      begin
         run_seen_q <= 1'b0;
         armed_q <= 1'b0;
         st_cnt_q <= mlsg_pkg::DLY_ZERO;
      end
      else if (clk_en)
      begin
         run_seen_q <= motor_running;
         if (!motor_running || !run_seen_q)
         begin
            armed_q <= 1'b0;
            st_cnt_q <= mlsg_pkg::DLY_ZERO;
         end
         else if (st_cnt_q >= start_dly)
            armed_q <= 1'b1;
         else if (tick_q)
            st_cnt_q <= st_cnt_q + mlsg_pkg::DLY_ONE;
      end
   end

   // ==========================================================
   // Stall elements, one instance each
   genvar gi;
   generate
      for (gi = 0; gi < mlsg_pkg::N_STALL; gi++)
      begin : g_stall
         mlsg_stall_elem u_elem
         (
            .ref_clk(ref_clk),
            .rst_b(rst_b),
            .clk_en(clk_en),
            .tick(tick_q),
            .armed(armed_q),
            .cur(cur),
            .run_dly(run_dly),
            .cfg(stall_cfg[gi]),
            .ind(stall_ind[gi])
         );
      end
   endgenerate

   // ==========================================================
   // Load relief
   logic active;
   logic above;
   logic below;
   logic shed_q;
   logic shed_d;
   logic [mlsg_pkg::DLY_W-1:0] pu_cnt_q;
   logic [mlsg_pkg::DLY_W-1:0] rl_cnt_q;

   assign active = load_relief_function.enable && motor_running;
   assign above = cur > load_relief_function.pickup;
   assign below = cur < load_relief_function.rel_lvl;

   // Shed state; both delays are whole ticks of qualified current
   always_comb
   begin
      shed_d = shed_q;
      if (!active)
         shed_d = 1'b0;
      else if (tick_q && !shed_q && above && pu_cnt_q >= load_relief_function.pu_dly)
         shed_d = 1'b1;
      else if (tick_q && shed_q && below && rl_cnt_q >= load_relief_function.rl_dly)
         shed_d = 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         shed_q <= 1'b0;
      else if (clk_en)
         shed_q <= shed_d;
   end

   // Pickup timer restarts whenever current dips
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         pu_cnt_q <= mlsg_pkg::DLY_ZERO;
      else if (clk_en)
      begin
         if (!active || !above || shed_q)
            pu_cnt_q <= mlsg_pkg::DLY_ZERO;
         else if (tick_q && pu_cnt_q < load_relief_function.pu_dly)
            pu_cnt_q <= pu_cnt_q + mlsg_pkg::DLY_ONE;
      end
   end

   // Release timer restarts if current climbs back
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         rl_cnt_q <= mlsg_pkg::DLY_ZERO;
      else if (clk_en)
      begin
         if (!active || !below || !shed_q)
            rl_cnt_q <= mlsg_pkg::DLY_ZERO;
         else if (tick_q && rl_cnt_q < load_relief_function.rl_dly)
            rl_cnt_q <= rl_cnt_q + mlsg_pkg::DLY_ONE;
      end
   end

   // Contact sense: open-to-shed contact idles closed, hence the inversion
   always_ff @(posedge ref_clk)
   begin
      if (!rst_b)
         relief_contact_q <= 1'b0;
      else if (clk_en)
         relief_contact_q <= shed_d ^ load_relief_function.open_contact;
   end

   // ==========================================================
   // Checks
   sequence s_stopped;
      clk_en && !active;
   endsequence

   property p_idle_when_stopped;
      @(posedge ref_clk) disable iff (!rst_b)
      s_stopped |=> !shed_q;
   endproperty
   a_idle_when_stopped: assert property (p_idle_when_stopped) else $error("Shed outside run state");

   property p_contact_sense;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en |=> relief_contact_q == (shed_q ^ $past(load_relief_function.open_contact));
   endproperty
   a_contact_sense: assert property (p_contact_sense) else $error("Contact sense wrong");

   property p_shed_rise;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(shed_q) |-> $past(above) && $past(tick_q) && $past(pu_cnt_q) >= $past(load_relief_function.pu_dly);
   endproperty
   a_shed_rise: assert property (p_shed_rise) else $error("Shed before pickup delay");

   property p_shed_fall;
      @(posedge ref_clk) disable iff (!rst_b)
      $fell(shed_q) && $past(active) |-> $past(below) && $past(rl_cnt_q) >= $past(load_relief_function.rl_dly);
   endproperty
   a_shed_fall: assert property (p_shed_fall) else $error("Release before release delay");

   property p_pu_restart;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && !above |=> pu_cnt_q == mlsg_pkg::DLY_ZERO;
   endproperty
   a_pu_restart: assert property (p_pu_restart) else $error("Pickup timer not restarted");

   // Release timer starts over when current climbs back
   property p_rl_restart;
      @(posedge ref_clk) disable iff (!rst_b)
      clk_en && !below |=> rl_cnt_q == mlsg_pkg::DLY_ZERO;
   endproperty
   a_rl_restart: assert property (p_rl_restart) else $error("Release timer not restarted");

   // Arming needs a running motor seen twice and the start delay spent
   property p_arm_wait;
      @(posedge ref_clk) disable iff (!rst_b)
      $rose(armed_q) |-> $past(motor_running) && $past(run_seen_q) && $past(st_cnt_q) >= $past(start_dly);
   endproperty
   a_arm_wait: assert property (p_arm_wait) else $error("Stall elements armed too early");

endmodule : mlsg_top

// file: test/mlsg_motor_model.sv
// Motor side model: measured load current and running state toward the guard.
// Assumes the bench calls its tasks; every change lands one step after a ref_clk edge.
module mlsg_motor_model
(
   // Clock
   input wire logic ref_clk,
   // Measurement and motor state
   output logic [mlsg_pkg::CUR_W-1:0] cur,
   output logic motor_running
);
   timeunit 1ns;
   timeprecision 100ps;

   // ==========================================================
   // Idle motor: stopped, no load
   initial
   begin
      cur = 16'h0000;
      motor_running = 1'b0;
   end

   // ==========================================================
   // Changes land just after the edge, so the guard never sees a half-settled level
   task automatic set_load(input logic [mlsg_pkg::CUR_W-1:0] amps);
      @(posedge ref_clk);
      #1;
      cur = amps;
   endtask : set_load

   task automatic set_run(input logic run);
      @(posedge ref_clk);
      #1;
      motor_running = run;
   endtask : set_run

endmodule : mlsg_motor_model

// file: test/testbench.sv
// Self-checking bench for the load-relief contact and the two stall-load elements.
// Assumes a shortened tick of 4 cycles; all delay settings are counted in those ticks.
`define CHK(what, exp, got) \
   begin \
      cmp_count++; \
      if ((got) !== (exp)) \
      begin \
         n_mismatch++; \
         $display("unexpected %s: expected %0h seen %0h", what, exp, got); \
      end \
   end
`define HOLD(what, exp, got, n) \
   for (int h = 0; h < (n); h++) \
   begin \
      step(); \
      `CHK(what, exp, got) \
   end
`define WAIT_FOR(cond, lim) \
   for (int w = 0; w < (lim) && !(cond); w++) \
      step();

module testbench;
   timeunit 1ns;
   timeprecision 100ps;

   localparam int TC = 4;
   localparam int WDOG_NS = 50000;

   logic ref_clk;
   logic rst_b;
   logic clk_en;
   logic [mlsg_pkg::CUR_W-1:0] cur;
   logic motor_running;
   mlsg_pkg::mlsg_relief_cfg_t relief;
   logic [mlsg_pkg::DLY_W-1:0] start_dly;
   logic [mlsg_pkg::DLY_W-1:0] run_dly;
   mlsg_pkg::mlsg_stall_cfg_t stall_cfg [mlsg_pkg::N_STALL];
   logic relief_contact_q;
   mlsg_pkg::mlsg_stall_out_t stall_ind [mlsg_pkg::N_STALL];
   int n_mismatch;
   int cmp_count;

   // ==========================================================
   // Design and motor model
   mlsg_top #(.TICK_CYCLES(TC)) dut_u
   (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .clk_en(clk_en),
      .cur(cur),
      .motor_running(motor_running),
      .load_relief_function(relief),
      .start_dly(start_dly),
      .run_dly(run_dly),
      .stall_cfg(stall_cfg),
      .relief_contact_q(relief_contact_q),
      .stall_ind(stall_ind)
   );

   mlsg_motor_model plant_u
   (
      .ref_clk(ref_clk),
      .cur(cur),
      .motor_running(motor_running)
   );

   // ==========================================================
   // Clock, 100 MHz
   initial
   begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   // One step past the edge: outputs settled, inputs safe to change
   task automatic step();
      @(posedge ref_clk);
      #1;
   endtask : step

   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : give_verdict

   // Hang guard: far longer than the sequence needs
   initial
   begin
      #(WDOG_NS);
      n_mismatch++;
      give_verdict();
   end

   // ==========================================================
   // Main sequence
   initial
   begin
      n_mismatch = 0;
      cmp_count = 0;
      rst_b = 1'b0;
      clk_en = 1'b1;
      relief = '{1'b1, 1'b0, 16'h0064, 16'h0050, 16'h0002, 16'h0001};
      start_dly = 16'h0002;
      run_dly = 16'h0003;
      stall_cfg[0] = '{1'b1, 1'b0, 16'h00c8, 16'h0001};
      stall_cfg[1] = '{1'b1, 1'b1, 16'h012c, 16'h0001};
      repeat (10) step();
      rst_b = 1'b1;
      `CHK("contact idle", 1'b0, relief_contact_q)
      // Shed only after the pickup delay, release only after the release delay
      plant_u.set_run(1'b1);
      plant_u.set_load(16'h0096);
      `HOLD("contact early", 1'b0, relief_contact_q, 2 * TC)
      `WAIT_FOR(relief_contact_q === 1'b1, 2 * TC)
      `CHK("contact shed", 1'b1, relief_contact_q)
      plant_u.set_load(16'h005a);
      `HOLD("contact above release", 1'b1, relief_contact_q, 4 * TC)
      plant_u.set_load(16'h0032);
      `HOLD("contact release wait", 1'b1, relief_contact_q, TC)
      `WAIT_FOR(relief_contact_q === 1'b0, 2 * TC)
      `CHK("contact released", 1'b0, relief_contact_q)
      // A short dip restarts the pickup delay
      plant_u.set_load(16'h0096);
      repeat (2 * TC - 1) step();
      plant_u.set_load(16'h0032);
      plant_u.set_load(16'h0096);
      `HOLD("contact after dip", 1'b0, relief_contact_q, 2 * TC)
      `WAIT_FOR(relief_contact_q === 1'b1, 2 * TC)
      `CHK("contact shed again", 1'b1, relief_contact_q)
      // Motor stop drops the shed and keeps the function idle
      plant_u.set_run(1'b0);
      `WAIT_FOR(relief_contact_q === 1'b0, 3)
      `CHK("contact on stop", 1'b0, relief_contact_q)
      `HOLD("contact stopped", 1'b0, relief_contact_q, 4 * TC)
      // Opening polarity: idle high, shed low
      relief.open_contact = 1'b1;
      repeat (2) step();
      `CHK("open idle", 1'b1, relief_contact_q)
      plant_u.set_run(1'b1);
      `WAIT_FOR(relief_contact_q === 1'b0, 4 * TC)
      `CHK("open shed", 1'b0, relief_contact_q)
      // Stall elements: start delay, alarm, trip, blocked trip
      plant_u.set_run(1'b0);
      plant_u.set_load(16'h0190);
      plant_u.set_run(1'b1);
      `HOLD("alarm in start delay", 1'b0, stall_ind[0].alarm, 4 * TC)
      `WAIT_FOR(stall_ind[0].alarm === 1'b1, 8 * TC)
      `CHK("alarm 0", 1'b1, stall_ind[0].alarm)
      `WAIT_FOR(stall_ind[1].alarm === 1'b1, 3)
      `CHK("alarm 1", 1'b1, stall_ind[1].alarm)
      `WAIT_FOR(stall_ind[0].trip === 1'b1, 3 * TC)
      `CHK("trip 0", 1'b1, stall_ind[0].trip)
      `HOLD("blocked element", 2'b10, stall_ind[1], 2 * TC)
      // Independent pickups and the 98 percent dropout
      plant_u.set_load(16'h00fa);
      `WAIT_FOR(stall_ind[1] === 2'b00, 3)
      `CHK("element 1 dropout", 2'b00, stall_ind[1])
      `HOLD("element 0 kept", 2'b11, stall_ind[0], 3 * TC)
      plant_u.set_load(16'h00c5);
      `HOLD("above 98 percent", 2'b11, stall_ind[0], 3 * TC)
      plant_u.set_load(16'h00c4);
      `WAIT_FOR(stall_ind[0] === 2'b00, 3)
      `CHK("at 98 percent", 2'b00, stall_ind[0])
      // A nine-cycle transient is filtered by the run delay
      plant_u.set_load(16'h0190);
      `HOLD("transient", 1'b0, stall_ind[0].alarm, 2 * TC)
      plant_u.set_load(16'h0000);
      `HOLD("transient gone", 1'b0, stall_ind[0].alarm, 2 * TC)
      // Mode turned off withdraws the trip, alarm stays
      plant_u.set_load(16'h0190);
      `WAIT_FOR(stall_ind[0].trip === 1'b1, 8 * TC)
      `CHK("trip again", 1'b1, stall_ind[0].trip)
      stall_cfg[0].trip_en = 1'b0;
      `WAIT_FOR(stall_ind[0].trip === 1'b0, 3)
      `HOLD("mode off", 2'b10, stall_ind[0], 2 * TC)
      // Element 1 trips on its own once unblocked; element 0 is untouched
      stall_cfg[1].trip_block = 1'b0;
      stall_cfg[1].trip_dly = 16'h0000;
      `WAIT_FOR(stall_ind[1].trip === 1'b1, 3)
      `CHK("element 1 trip", 2'b11, stall_ind[1])
      `CHK("element 0 untouched", 2'b10, stall_ind[0])
      stall_cfg[1].trip_en = 1'b0;
      `WAIT_FOR(stall_ind[1].trip === 1'b0, 3)
      `CHK("element 1 mode off", 2'b10, stall_ind[1])
      // A lowered trip delay acts at once, but only when not blocked
      stall_cfg[0].trip_en = 1'b1;
      stall_cfg[0].trip_block = 1'b1;
      stall_cfg[0].trip_dly = 16'h0000;
      `HOLD("element 0 blocked", 2'b10, stall_ind[0], 2 * TC)
      stall_cfg[0].trip_block = 1'b0;
      `WAIT_FOR(stall_ind[0].trip === 1'b1, 3)
      `CHK("element 0 unblocked", 2'b11, stall_ind[0])
      // Clock enable low freezes indications and contact
      clk_en = 1'b0;
      plant_u.set_load(16'h0000);
      `HOLD("frozen element", 2'b11, stall_ind[0], 2 * TC)
      `CHK("frozen contact", 1'b0, relief_contact_q)
      clk_en = 1'b1;
      `WAIT_FOR(stall_ind[0] === 2'b00, 3)
      `CHK("dropout after freeze", 2'b00, stall_ind[0])
      // Disabled function never sheds; zero delays act on the next tick
      relief.enable = 1'b0;
      relief.pu_dly = 16'h0000;
      relief.rl_dly = 16'h0000;
      plant_u.set_load(16'h0190);
      `HOLD("disabled", 1'b1, relief_contact_q, 4 * TC)
      relief.enable = 1'b1;
      `WAIT_FOR(relief_contact_q === 1'b0, TC + 2)
      `CHK("zero pickup delay", 1'b0, relief_contact_q)
      plant_u.set_load(16'h0032);
      `WAIT_FOR(relief_contact_q === 1'b1, TC + 2)
      `CHK("zero release delay", 1'b1, relief_contact_q)
      // Zero start and run delays: alarm soon after a start, gone after a stop
      plant_u.set_run(1'b0);
      start_dly = 16'h0000;
      run_dly = 16'h0000;
      plant_u.set_load(16'h0190);
      `CHK("alarm when stopped", 1'b0, stall_ind[0].alarm)
      plant_u.set_run(1'b1);
      `WAIT_FOR(stall_ind[0].alarm === 1'b1, 6)
      `CHK("alarm without delays", 1'b1, stall_ind[0].alarm)
      plant_u.set_run(1'b0);
      `WAIT_FOR(stall_ind[0] === 2'b00, 4)
      `CHK("stop clears element", 2'b00, stall_ind[0])
      give_verdict();
   end

endmodule : testbench
